// ===== start_select_pkg.sv
package start_select_pkg;

  // ------------------------------------------------------------------
  // BEMF constant code layout
  // ------------------------------------------------------------------
  localparam int unsigned CODE_W       = 7;
  localparam int unsigned MANT_LSB     = 0;
  localparam int unsigned MANT_W       = 4;
  localparam int unsigned EXP_LSB      = 4;
  localparam int unsigned EXP_W        = 3;
  localparam int unsigned WEIGHT_W     = 11;
  localparam int unsigned STEP_UV_HZ   = 920;
  localparam int unsigned MAX_UV_HZ    = 1766400;
  localparam int unsigned MICRO_W      = 21;

  // ------------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------------
  localparam int unsigned CLK_HZ       = 25000000;
  localparam int unsigned STILL_TIMEOUT_US  = 100000;
  localparam int unsigned STILL_TIMEOUT_CYC =
    (STILL_TIMEOUT_US * (CLK_HZ / 1000000));
  localparam int unsigned CNT_W        = 24;

  // ------------------------------------------------------------------
  // Sequencer states and start paths
  // ------------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_POWER_ON,
    ST_SPEED_DETECT,
    ST_JUDGE,
    ST_BRAKE,
    ST_COAST,
    ST_INIT,
    ST_POSITION_DETECT,
    ST_ALIGN,
    ST_ACCEL,
    ST_REVERSE,
    ST_CLOSED
  } seq_state_t;

  typedef enum logic [1:0] {
    PATH_NONE,
    PATH_STATIONARY,
    PATH_FORWARD,
    PATH_REVERSE
  } start_path_t;

  typedef enum logic [1:0] {
    DIR_STILL,
    DIR_FORWARD,
    DIR_REVERSE
  } spin_dir_t;

endpackage : start_select_pkg

// ===== spin_sense_if.sv
`timescale 1ns/10ps
`default_nettype none
interface spin_sense_if;
  logic       cmp_a;
  logic       cmp_b;
  logic       clear;
  logic       valid;
  logic [1:0] dir;
  modport sensor (input cmp_a, input cmp_b, input clear,
                  output valid, output dir);
  modport user   (output cmp_a, output cmp_b, output clear,
                  input valid, input dir);
endinterface : spin_sense_if
`default_nettype wire

// ===== spin_sense.sv
`timescale 1ns/10ps
`default_nettype none
module spin_sense #(
  parameter int unsigned STILL_CYC = start_select_pkg::STILL_TIMEOUT_CYC
) (
  input  wire logic    ref_clk_i,
  input  wire logic    rst_n_i,
  spin_sense_if.sensor ss
);
  if (STILL_CYC < 2 ||
      STILL_CYC >= (1 << start_select_pkg::CNT_W)) begin : g_bad_still
    $error("spin_sense: STILL_CYC out of range");
  end

  logic                              a_reg;
  logic                              a_next;
  logic [start_select_pkg::CNT_W-1:0] cnt_reg;
  logic [start_select_pkg::CNT_W-1:0] cnt_next;
  logic                              valid_reg;
  logic                              valid_next;
  logic [1:0]                        dir_reg;
  logic [1:0]                        dir_next;

  // ------------------------------------------------------------------
  // Direction decode
  // ------------------------------------------------------------------
  always_comb begin
    a_next     = ss.cmp_a;
    cnt_next   = cnt_reg;
    valid_next = valid_reg;
    dir_next   = dir_reg;
    if (ss.clear) begin
      valid_next = 1'b0;
      cnt_next   = '0;
    end else if (!valid_reg) begin
      // [R13] Lead or lag.
      if (ss.cmp_a && !a_reg) begin
        valid_next = 1'b1;
        dir_next   = ss.cmp_b ? start_select_pkg::DIR_REVERSE
                              : start_select_pkg::DIR_FORWARD;
      end else if (cnt_reg == STILL_CYC[start_select_pkg::CNT_W-1:0]) begin
        valid_next = 1'b1;
        dir_next   = start_select_pkg::DIR_STILL;
      end else begin
        cnt_next = cnt_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      a_reg     <= 1'b0;
      cnt_reg   <= '0;
      valid_reg <= 1'b0;
      dir_reg   <= 2'h0;
    end else begin
      a_reg     <= a_next;
      cnt_reg   <= cnt_next;
      valid_reg <= valid_next;
      dir_reg   <= dir_next;
    end
  end

  assign ss.valid = valid_reg;
  assign ss.dir   = dir_reg;
endmodule : spin_sense
`default_nettype wire

// ===== motor_start_condition_select.sv
// Operation
// [R1] Code 0x00 is zero, each step weighs 0.92 mV/Hz, 0x7F is 1766.4.
// [R2] The weight is the mantissa shifted left by the exponent.
// [R3] Each start classifies the rotor as still, forward or reverse.
// [R4] A still rotor is brought into phase by one of two methods.
// [R5] Position detect infers the angle from winding inductance.
// [R6] Alignment drives a fixed phase pattern to pull the rotor in.
// [R7] A forward rotor, if enabled, is resynchronised to closed loop.
// [R8] With reverse drive a backward rotor is driven through zero speed.
// [R9] Without reverse drive a backward rotor coasts or is braked.
// [R10] After coasting or braking the start goes on as for a still rotor.
// [R11] The configurer keeps reverse and brake current and surge safe.
// [R12] Brake turns on all low sides and ends after low current for time.
// [R13] Second comparator lagging by 60 degrees is forward, leading reverse.
// [R14] One path per attempt, and a restart after power-up or standby.
`timescale 1ns/10ps
`default_nettype none
module motor_start_condition_select #(
  parameter int unsigned STILL_CYC = start_select_pkg::STILL_TIMEOUT_CYC
) (
  input  wire logic        ref_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        standby_i,
  input  wire logic        start_i,
  input  wire logic [6:0]  bemf_constant_code_i,
  input  wire logic        speed_detect_enable_i,
  input  wire logic        resync_enable_i,
  input  wire logic        reverse_drive_enable_i,
  input  wire logic        brake_enable_i,
  input  wire logic        position_detect_enable_i,
  input  wire logic        cmp_uv_i,
  input  wire logic        cmp_uw_i,
  input  wire logic        phase_current_low_i,
  input  wire logic        brake_exit_time_done_i,
  input  wire logic        init_done_i,
  input  wire logic        reverse_zero_speed_i,
  input  wire logic        accel_done_i,
  output logic [10:0]      bemf_constant_weight_o,
  output logic [20:0]      bemf_constant_uv_hz_o,
  output logic [1:0]       start_path_o,
  output logic             path_strobe_o,
  output logic             initial_position_detect_o,
  output logic             align_drive_o,
  output logic             brake_low_sides_o,
  output logic             reverse_drive_o,
  output logic             accelerate_o,
  output logic             closed_loop_o,
  output logic [3:0]       state_o
);
  // ------------------------------------------------------------------
  // Code decode
  // ------------------------------------------------------------------
  function automatic logic [10:0] weight_of(input logic [6:0] code);
    weight_of =
      11'(code[start_select_pkg::MANT_LSB +: start_select_pkg::MANT_W]) <<
      code[start_select_pkg::EXP_LSB +: start_select_pkg::EXP_W];
  endfunction : weight_of

  logic [10:0] weight_reg;
  logic [10:0] weight_next;
  logic [20:0] uv_reg;
  logic [20:0] uv_next;

  always_comb begin
    // [R2] Mantissa shifted.
    weight_next = weight_of(bemf_constant_code_i);
    // [R1] Step weight scaling.
    uv_next = 21'(32'(weight_next) * start_select_pkg::STEP_UV_HZ);
  end

  // ------------------------------------------------------------------
  // Synchronisers
  // ------------------------------------------------------------------
  logic [1:0] uv_sync_reg;
  logic [1:0] uw_sync_reg;
  logic [1:0] uv_sync_next;
  logic [1:0] uw_sync_next;

  always_comb begin
    uv_sync_next = {uv_sync_reg[0], cmp_uv_i};
    uw_sync_next = {uw_sync_reg[0], cmp_uw_i};
  end

  spin_sense_if ss ();
  assign ss.cmp_a = uv_sync_reg[1];
  assign ss.cmp_b = uw_sync_reg[1];

  spin_sense #(
    .STILL_CYC (STILL_CYC)
  ) u_spin_sense (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .ss        (ss)
  );

  // ------------------------------------------------------------------
  // Start sequencer
  // ------------------------------------------------------------------
  start_select_pkg::seq_state_t  st_reg;
  start_select_pkg::seq_state_t  st_next;
  start_select_pkg::start_path_t path_reg;
  start_select_pkg::start_path_t path_next;
  logic                          strobe_reg;
  logic                          strobe_next;
  logic                          clear_reg;
  logic                          clear_next;

  assign ss.clear = clear_reg;

  always_comb begin
    st_next     = st_reg;
    path_next   = path_reg;
    strobe_next = 1'b0;
    clear_next  = 1'b0;
    case (st_reg)
      start_select_pkg::ST_POWER_ON: begin
        if (start_i) begin
          path_next = start_select_pkg::PATH_NONE;
          if (speed_detect_enable_i) begin
            clear_next = 1'b1;
            st_next    = start_select_pkg::ST_SPEED_DETECT;
          end else begin
            // [R3] Disabled sensing means still.
            path_next   = start_select_pkg::PATH_STATIONARY;
            strobe_next = 1'b1;
            st_next     = start_select_pkg::ST_INIT;
          end
        end
      end
      start_select_pkg::ST_SPEED_DETECT: begin
        if (ss.valid && !clear_reg) begin
          st_next = start_select_pkg::ST_JUDGE;
        end
      end
      start_select_pkg::ST_JUDGE: begin
        // [R14] Single path strobe.
        strobe_next = 1'b1;
        // [R3] Classify rotor condition.
        case (ss.dir)
          start_select_pkg::DIR_FORWARD: begin
            path_next = start_select_pkg::PATH_FORWARD;
            // [R7] Resync to closed.
            st_next = resync_enable_i ? start_select_pkg::ST_CLOSED
                                      : start_select_pkg::ST_INIT;
          end
          start_select_pkg::DIR_REVERSE: begin
            path_next = start_select_pkg::PATH_REVERSE;
            // [R8] Reverse drive path.
            if (reverse_drive_enable_i) begin
              st_next = start_select_pkg::ST_REVERSE;
            // [R9] Brake or coast.
            end else if (brake_enable_i) begin
              st_next = start_select_pkg::ST_BRAKE;
            end else begin
              clear_next = 1'b1;
              st_next    = start_select_pkg::ST_COAST;
            end
          end
          default: begin
            path_next = start_select_pkg::PATH_STATIONARY;
            st_next   = start_select_pkg::ST_INIT;
          end
        endcase
      end
      start_select_pkg::ST_BRAKE: begin
        // [R12] Exit on low current.
        if (phase_current_low_i && brake_exit_time_done_i) begin
          // [R10] Continue as still.
          st_next = start_select_pkg::ST_INIT;
        end
      end
      start_select_pkg::ST_COAST: begin
        // [R10] Coasted to rest.
        if (ss.valid && !clear_reg) begin
          if (ss.dir == start_select_pkg::DIR_STILL) begin
            st_next = start_select_pkg::ST_INIT;
          end else begin
            clear_next = 1'b1;
          end
        end
      end
      start_select_pkg::ST_INIT: begin
        // [R4] Pick initialization method.
        st_next = position_detect_enable_i
                    ? start_select_pkg::ST_POSITION_DETECT
                    : start_select_pkg::ST_ALIGN;
      end
      start_select_pkg::ST_POSITION_DETECT,
      start_select_pkg::ST_ALIGN: begin
        if (init_done_i) begin
          st_next = start_select_pkg::ST_ACCEL;
        end
      end
      start_select_pkg::ST_REVERSE: begin
        if (reverse_zero_speed_i) begin
          st_next = start_select_pkg::ST_ACCEL;
        end
      end
      start_select_pkg::ST_ACCEL: begin
        if (accel_done_i) begin
          st_next = start_select_pkg::ST_CLOSED;
        end
      end
      start_select_pkg::ST_CLOSED: begin
        st_next = st_reg;
      end
      default: begin
        st_next = start_select_pkg::ST_POWER_ON;
      end
    endcase
    // [R14] Standby restarts sequencer.
    if (standby_i) begin
      st_next     = start_select_pkg::ST_POWER_ON;
      path_next   = start_select_pkg::PATH_NONE;
      strobe_next = 1'b0;
      clear_next  = 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      st_reg      <= start_select_pkg::ST_POWER_ON;
      path_reg    <= start_select_pkg::PATH_NONE;
      strobe_reg  <= 1'b0;
      clear_reg   <= 1'b0;
      uv_sync_reg <= 2'h0;
      uw_sync_reg <= 2'h0;
      weight_reg  <= 11'h000;
      uv_reg      <= 21'h000000;
    end else begin
      st_reg      <= st_next;
      path_reg    <= path_next;
      strobe_reg  <= strobe_next;
      clear_reg   <= clear_next;
      uv_sync_reg <= uv_sync_next;
      uw_sync_reg <= uw_sync_next;
      weight_reg  <= weight_next;
      uv_reg      <= uv_next;
    end
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  logic [5:0] drv_reg;
  logic [5:0] drv_next;

  always_comb begin
    // [R5] Inductance position sensing.
    drv_next[0] = (st_next == start_select_pkg::ST_POSITION_DETECT);
    // [R6] Fixed phase align.
    drv_next[1] = (st_next == start_select_pkg::ST_ALIGN);
    // [R12] All low sides on.
    drv_next[2] = (st_next == start_select_pkg::ST_BRAKE);
    // [R8] Drive through zero.
    drv_next[3] = (st_next == start_select_pkg::ST_REVERSE);
    drv_next[4] = (st_next == start_select_pkg::ST_ACCEL);
    drv_next[5] = (st_next == start_select_pkg::ST_CLOSED);
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      drv_reg <= 6'h00;
    end else begin
      drv_reg <= drv_next;
    end
  end

  assign bemf_constant_weight_o    = weight_reg;
  assign bemf_constant_uv_hz_o     = uv_reg;
  assign start_path_o              = path_reg;
  assign path_strobe_o             = strobe_reg;
  assign initial_position_detect_o = drv_reg[0];
  assign align_drive_o             = drv_reg[1];
  assign brake_low_sides_o         = drv_reg[2];
  assign reverse_drive_o           = drv_reg[3];
  assign accelerate_o              = drv_reg[4];
  assign closed_loop_o             = drv_reg[5];
  assign state_o                   = st_reg;
endmodule : motor_start_condition_select
`default_nettype wire

// ===== start_select_properties.sv
`timescale 1ns/10ps
`default_nettype none
module start_select_properties #(
  parameter int unsigned STILL_CYC = start_select_pkg::STILL_TIMEOUT_CYC
) (
  input wire logic        ref_clk_i,
  input wire logic        rst_n_i,
  input wire logic        standby_i,
  input wire logic        start_i,
  input wire logic [6:0]  bemf_constant_code_i,
  input wire logic        speed_detect_enable_i,
  input wire logic        phase_current_low_i,
  input wire logic        brake_exit_time_done_i,
  input wire logic [10:0] bemf_constant_weight_o,
  input wire logic [20:0] bemf_constant_uv_hz_o,
  input wire logic [1:0]  start_path_o,
  input wire logic        path_strobe_o,
  input wire logic        initial_position_detect_o,
  input wire logic        align_drive_o,
  input wire logic        brake_low_sides_o,
  input wire logic        reverse_drive_o,
  input wire logic        accelerate_o,
  input wire logic        closed_loop_o,
  input wire logic [3:0]  state_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  a_weight_shift: assert property (
    $past(rst_n_i) |-> bemf_constant_weight_o ==
      (11'($past(bemf_constant_code_i[3:0]))
        << $past(bemf_constant_code_i[6:4])))
    else $error("weight wrong");
  a_uv_scale: assert property (
    bemf_constant_uv_hz_o == {10'h0, bemf_constant_weight_o} * 21'h398)
    else $error("uv_hz wrong");
  a_strobe_pulse: assert property (
    path_strobe_o |=> !path_strobe_o) else $error("strobe long");
  a_strobe_path: assert property (
    path_strobe_o |-> start_path_o != 2'h0) else $error("no path");
  a_quick_path: assert property (
    state_o == 4'h0 && start_i && !standby_i && !speed_detect_enable_i
      |=> path_strobe_o && start_path_o == 2'h1)
    else $error("no still path");
  a_standby_home: assert property (
    standby_i |=> state_o == 4'h0) else $error("no restart");
  a_path_hold: assert property (
    $past(rst_n_i) && !$past(standby_i) && !path_strobe_o
      |-> $stable(start_path_o)) else $error("path moved");
  a_brake_exit: assert property (
    brake_low_sides_o && phase_current_low_i && brake_exit_time_done_i
      |-> ##[1:3] !brake_low_sides_o) else $error("brake stuck");
  a_one_drive: assert property (
    $onehot0({initial_position_detect_o, align_drive_o, brake_low_sides_o,
      reverse_drive_o, accelerate_o, closed_loop_o}))
    else $error("two drives");
  a_closed_stay: assert property (
    $past(rst_n_i) && !$past(standby_i) && !standby_i && closed_loop_o
      |=> closed_loop_o) else $error("left closed loop");
endmodule : start_select_properties

bind motor_start_condition_select start_select_properties #(
  .STILL_CYC(STILL_CYC)
) u_start_select_properties (.*);
`default_nettype wire

// ===== motor_windings_model.sv
`timescale 1ns/10ps
`default_nettype none
module motor_windings_model (
  input  wire logic       ref_clk_i,
  input  wire logic [1:0] spin_i,
  input  wire logic       brake_i,
  output logic            cmp_uv_o,
  output logic            cmp_uw_o
);
  logic [3:0] t_reg = 4'h0;
  logic       stop_reg = 1'b0;
  always @(posedge ref_clk_i) begin
    if (brake_i)
      stop_reg <= 1'b1;
    else if (spin_i == 2'h0)
      stop_reg <= 1'b0;
    if (!stop_reg && spin_i == 2'h1)
      t_reg <= (t_reg == 4'hb) ? 4'h0 : t_reg + 4'h1;
    else if (!stop_reg && spin_i == 2'h2)
      t_reg <= (t_reg == 4'h0) ? 4'hb : t_reg - 4'h1;
  end
  assign cmp_uv_o = t_reg[3:1] < 3'h3;
  assign cmp_uw_o = t_reg[3:1] != 3'h0 && t_reg[3:1] < 3'h4;
endmodule : motor_windings_model
`default_nettype wire

// ===== motor_start_condition_select_tb.sv
`timescale 1ns/10ps
`default_nettype none
module motor_start_condition_select_tb;
  logic        ref_clk_i, rst_n_i, standby_i, start_i;
  logic [6:0]  bemf_constant_code_i;
  logic        speed_detect_enable_i, resync_enable_i;
  logic        reverse_drive_enable_i, brake_enable_i;
  logic        position_detect_enable_i, cmp_uv_i, cmp_uw_i;
  logic        phase_current_low_i, brake_exit_time_done_i;
  logic        init_done_i, reverse_zero_speed_i, accel_done_i;
  logic [10:0] bemf_constant_weight_o;
  logic [20:0] bemf_constant_uv_hz_o;
  logic [1:0]  start_path_o, spin;
  logic        path_strobe_o, initial_position_detect_o, align_drive_o;
  logic        brake_low_sides_o, reverse_drive_o, accelerate_o;
  logic        closed_loop_o;
  logic [3:0]  state_o;
  int          bad_count, cmp_count;
  logic [31:0] seed = 32'hbdeb4b51;
  logic [31:0] r, rr, e;
  logic [31:0] wq[$];
  logic [1:0]  pq[$];

  motor_start_condition_select #(.STILL_CYC(20))
    u_motor_start_condition_select (.*);
  motor_windings_model u_motor_windings_model (
    .ref_clk_i (ref_clk_i),
    .spin_i    (spin),
    .brake_i   (brake_low_sides_o),
    .cmp_uv_o  (cmp_uv_i),
    .cmp_uw_o  (cmp_uw_i)
  );

  always #20 ref_clk_i = ~ref_clk_i;

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  task automatic check(input string n, input logic [31:0] x,
                       input logic [31:0] s);
    cmp_count++;
    if (s !== x) begin
      bad_count++;
      $display("[ERR] %s exp %h got %h", n, x, s);
    end
  endtask : check

  task automatic stop_test();
    $display("checks %0d errors %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : stop_test

  always @(negedge ref_clk_i) begin
    rr = xs();
    init_done_i <= rr[0] & (initial_position_detect_o | align_drive_o);
    accel_done_i <= rr[1] & accelerate_o;
    reverse_zero_speed_i <= rr[2] & reverse_drive_o;
    phase_current_low_i <= rr[3] & brake_low_sides_o;
    brake_exit_time_done_i <= rr[4] & brake_low_sides_o;
  end

  always @(posedge ref_clk_i) begin
    #2;
    if (wq.size() > 0) begin
      e = wq.pop_front();
      check("weight", e, {21'h0, bemf_constant_weight_o});
      check("uv_hz", e * 32'h398, {11'h0, bemf_constant_uv_hz_o});
    end
    if (path_strobe_o === 1'b1 && pq.size() == 0)
      check("strobe", 32'h0, 32'h1);
    else if (path_strobe_o === 1'b1)
      check("path", {30'h0, pq.pop_front()}, {30'h0, start_path_o});
  end

  task automatic run(input logic [4:0] cfg, input logic [1:0] sp,
                     input logic [1:0] path, input logic [5:0] xm,
                     input int stop_at);
    logic [5:0] m;
    m = 6'h0;
    standby_i = 1'b1;
    spin = 2'h0;
    {speed_detect_enable_i, resync_enable_i, reverse_drive_enable_i,
     brake_enable_i, position_detect_enable_i} = cfg;
    repeat (2) @(negedge ref_clk_i);
    check("state", 32'h0, {28'h0, state_o});
    standby_i = 1'b0;
    spin = sp;
    pq.push_back(path);
    start_i = 1'b1;
    for (int n = 0; n < 400 && closed_loop_o !== 1'b1; n++) begin
      @(negedge ref_clk_i);
      start_i = 1'b0;
      if (n == stop_at)
        spin = 2'h0;
      m |= {initial_position_detect_o, align_drive_o, brake_low_sides_o,
            reverse_drive_o, accelerate_o, closed_loop_o};
    end
    check("drive", {26'h0, xm}, {26'h0, m});
    check("left", 32'h0, 32'(pq.size()));
    start_i = 1'b1;
    @(negedge ref_clk_i);
    start_i = 1'b0;
    repeat (3) @(negedge ref_clk_i);
  endtask : run

  initial begin
    logic [6:0] c;
    ref_clk_i = 1'b0;
    {rst_n_i, standby_i, start_i, speed_detect_enable_i, resync_enable_i,
     reverse_drive_enable_i, brake_enable_i, position_detect_enable_i} = 8'h0;
    bemf_constant_code_i = 7'h0;
    spin = 2'h0;
    repeat (16) @(negedge ref_clk_i);
    rst_n_i = 1'b1;
    for (int i = 0; i < 160; i++) begin
      @(negedge ref_clk_i);
      r = xs();
      c = (i < 128) ? 7'(i) : r[6:0];
      bemf_constant_code_i = c;
      wq.push_back(32'(11'(c[3:0]) << c[6:4]));
    end
    run(5'h01, 2'h0, 2'h1, 6'h23, -1);
    run(5'h00, 2'h0, 2'h1, 6'h13, -1);
    run(5'h11, 2'h0, 2'h1, 6'h23, -1);
    run(5'h18, 2'h1, 2'h2, 6'h01, -1);
    run(5'h14, 2'h2, 2'h3, 6'h07, -1);
    run(5'h12, 2'h2, 2'h3, 6'h1b, -1);
    run(5'h11, 2'h2, 2'h3, 6'h23, 60);
    stop_test();
  end

  initial begin
    repeat (8000) @(posedge ref_clk_i);
    bad_count++;
    stop_test();
  end
endmodule : motor_start_condition_select_tb
`default_nettype wire
